// File: rtl/sppr_map.svh
`ifndef SPPR_MAP_SVH
`define SPPR_MAP_SVH

// ----------------------------------------
// Register addresses in the SFR space
// ----------------------------------------
`define SPPR_ADDR_PORT0 8'h80
`define SPPR_ADDR_POWER 8'h87
`define SPPR_ADDR_PORT1 8'h90
`define SPPR_ADDR_PORT2 8'hA0
`define SPPR_ADDR_PORT3 8'hB0
`define SPPR_ADDR_PRIO_UPPER 8'hB7
`define SPPR_ADDR_PRIO_LOWER 8'hB8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPPR_RST_PORT 8'hFF
`define SPPR_RST_POWER 8'h00
`define SPPR_RST_PRIO 7'h00

// ----------------------------------------
// Power control field positions
// ----------------------------------------
`define SPPR_PC_BAUD_DOUBLER 7
`define SPPR_PC_BIT7_SELECT 6
`define SPPR_PC_RESERVED 5
`define SPPR_PC_SUPPLY_LOSS 4
`define SPPR_PC_USER_B 3
`define SPPR_PC_USER_A 2
`define SPPR_PC_POWERDOWN 1
`define SPPR_PC_SLEEP 0

// ----------------------------------------
// Priority bit positions, one per source
// ----------------------------------------
`define SPPR_SRC_COUNTER_ARRAY 6
`define SPPR_SRC_TIMER2 5
`define SPPR_SRC_SERIAL 4
`define SPPR_SRC_TIMER1 3
`define SPPR_SRC_EXT1 2
`define SPPR_SRC_TIMER0 1
`define SPPR_SRC_EXT0 0
`define SPPR_NUM_SRC 7

// Port 0 latch value forced by an external bus cycle
`define SPPR_BUS_CYCLE_FILL 8'hFF

`endif

// File: rtl/sppr_pkg.sv
package sppr_pkg;

  // ----------------------------------------
  // Types shared by the bank and its users
  // ----------------------------------------
  typedef logic [1:0] sppr_level_type;

  // CPU access to one SFR
  typedef struct packed {
    logic rd;
    logic wr;
    logic rmw;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sppr_access_type;

  // Power and serial controls seen by the clock unit and serial port
  typedef struct packed {
    logic baud_doubler;
    logic serial_bit7_select;
    logic powerdown;
    logic idle;
  } sppr_power_type;

  // Overall low-power mode after precedence
  typedef enum logic [1:0] {
    SPPR_MODE_RUN = 2'b00,
    SPPR_MODE_IDLE = 2'b01,
    SPPR_MODE_POWERDOWN = 2'b11
  } sppr_mode_type;

endpackage

// File: rtl/sppr_bank.sv
`timescale 1ns/1ps
`include "sppr_map.svh"
// Notes on behaviour
// - Level is upper bit then lower bit
// - Bits 6..0 map seven interrupt sources
// - Reserved bits read zero, software writes zero
// - Port latches reset to ones, drive pins
// - Latch write updates driven pin data
// - Read-modify-write reads latch, others read pins
// - External bus cycle fills port 0 latch
// - Baud doubled with timer 1, modes 1-3
// - Power bit 6 steers serial bit 7
// - Supply-loss flag set by hardware or software
// - Two user flags with no hardware effect
// - Powerdown bit cleared by interrupt or reset
// - Idle bit cleared by interrupt or reset
// - Powerdown wins over idle
module sppr_bank
(
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire sppr_pkg::sppr_access_type ACCESS,
  output logic [7:0] RDATA,
  output logic RVALID,
  input wire logic [7:0] PORT0_PINS,
  input wire logic [7:0] PORT1_PINS,
  input wire logic [7:0] PORT2_PINS,
  input wire logic [7:0] PORT3_PINS,
  output logic [7:0] PORT0_OUT,
  output logic [7:0] PORT1_OUT,
  output logic [7:0] PORT2_OUT,
  output logic [7:0] PORT3_OUT,
  input wire logic EXT_BUS_CYCLE,
  input wire logic SUPPLY_RESTORED,
  input wire logic INTERRUPT_TAKEN,
  input wire logic TIMER1_BAUD_SEL,
  input wire logic [1:0] SERIAL_MODE,
  output logic [13:0] PRIORITY_LEVELS,
  output sppr_pkg::sppr_power_type POWER_CTRL,
  output sppr_pkg::sppr_mode_type POWER_MODE,
  output logic BAUD_DOUBLE_ACTIVE
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [31:0] pins_meta_reg;
  logic [31:0] pins_sync_reg;
  logic supply_meta_reg;
  logic supply_sync_reg;
  logic supply_seen_reg;

  // Pins and the supply monitor are asynchronous, so two stages each
  always_ff @(posedge CORE_CLK)
  begin
    pins_meta_reg <= {PORT3_PINS, PORT2_PINS, PORT1_PINS, PORT0_PINS};
    pins_sync_reg <= pins_meta_reg;
    supply_meta_reg <= SUPPLY_RESTORED;
    supply_sync_reg <= supply_meta_reg;
    supply_seen_reg <= supply_sync_reg;
  end

  // Rising edge of the restored-supply indication, read off the second stage
  logic supply_rise;
  assign supply_rise = supply_sync_reg && !supply_seen_reg;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = addr == target;
  endfunction

  logic wr_p0, wr_p1, wr_p2, wr_p3, wr_pc, wr_ipu, wr_ipl;
  assign wr_p0 = ACCESS.wr && hit(ACCESS.addr, `SPPR_ADDR_PORT0);
  assign wr_p1 = ACCESS.wr && hit(ACCESS.addr, `SPPR_ADDR_PORT1);
  assign wr_p2 = ACCESS.wr && hit(ACCESS.addr, `SPPR_ADDR_PORT2);
  assign wr_p3 = ACCESS.wr && hit(ACCESS.addr, `SPPR_ADDR_PORT3);
  assign wr_pc = ACCESS.wr && hit(ACCESS.addr, `SPPR_ADDR_POWER);
  assign wr_ipu = ACCESS.wr && hit(ACCESS.addr, `SPPR_ADDR_PRIO_UPPER);
  assign wr_ipl = ACCESS.wr && hit(ACCESS.addr, `SPPR_ADDR_PRIO_LOWER);

  // ----------------------------------------
  // Port output latches
  // ----------------------------------------
  logic [7:0] port0_output_latch_reg;
  logic [7:0] port1_output_latch_reg;
  logic [7:0] port2_output_latch_reg;
  logic [7:0] port3_output_latch_reg;

  // Bus cycle wins over a CPU write: the address/data mux needs a high latch
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      port0_output_latch_reg <= `SPPR_RST_PORT;
    else if (EXT_BUS_CYCLE)
      port0_output_latch_reg <= `SPPR_BUS_CYCLE_FILL;
    else if (wr_p0)
      port0_output_latch_reg <= ACCESS.wdata;
  end

  // Ports 1 to 3 are plain latches
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      port1_output_latch_reg <= `SPPR_RST_PORT;
      port2_output_latch_reg <= `SPPR_RST_PORT;
      port3_output_latch_reg <= `SPPR_RST_PORT;
    end
    else
    begin
      if (wr_p1)
        port1_output_latch_reg <= ACCESS.wdata;
      if (wr_p2)
        port2_output_latch_reg <= ACCESS.wdata;
      if (wr_p3)
        port3_output_latch_reg <= ACCESS.wdata;
    end
  end

  // Latches drive the pins directly
  assign PORT0_OUT = port0_output_latch_reg;
  assign PORT1_OUT = port1_output_latch_reg;
  assign PORT2_OUT = port2_output_latch_reg;
  assign PORT3_OUT = port3_output_latch_reg;

  // ----------------------------------------
  // Interrupt priority registers
  // ----------------------------------------
  logic [6:0] interrupt_priority_upper_reg;
  logic [6:0] interrupt_priority_lower_reg;

  // Bit 7 is not stored; it always reads zero
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      interrupt_priority_upper_reg <= `SPPR_RST_PRIO;
      interrupt_priority_lower_reg <= `SPPR_RST_PRIO;
    end
    else
    begin
      if (wr_ipu)
        interrupt_priority_upper_reg <= ACCESS.wdata[6:0];
      if (wr_ipl)
        interrupt_priority_lower_reg <= ACCESS.wdata[6:0];
    end
  end

  // Level of source n sits at bits 2n+1:2n, upper bit first
  always_comb
  begin
    PRIORITY_LEVELS = 14'h0000;
    for (int n = 0; n < `SPPR_NUM_SRC; n++)
    begin
      PRIORITY_LEVELS[2*n+1] = interrupt_priority_upper_reg[n];
      PRIORITY_LEVELS[2*n] = interrupt_priority_lower_reg[n];
    end
  end

  // ----------------------------------------
  // Power control register
  // ----------------------------------------
  logic baud_doubler_reg;
  logic serial_bit7_select_reg;
  logic supply_loss_flag_reg;
  logic user_flag_b_reg;
  logic user_flag_a_reg;
  logic powerdown_request_reg;
  logic cpu_sleep_request_reg;

  // Serial controls and user flags are plain software bits
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      baud_doubler_reg <= 1'b0;
      serial_bit7_select_reg <= 1'b0;
      user_flag_b_reg <= 1'b0;
      user_flag_a_reg <= 1'b0;
    end
    else if (wr_pc)
    begin
      baud_doubler_reg <= ACCESS.wdata[`SPPR_PC_BAUD_DOUBLER];
      serial_bit7_select_reg <= ACCESS.wdata[`SPPR_PC_BIT7_SELECT];
      user_flag_b_reg <= ACCESS.wdata[`SPPR_PC_USER_B];
      user_flag_a_reg <= ACCESS.wdata[`SPPR_PC_USER_A];
    end
  end

  // Supply-loss flag survives the core reset; hardware set beats a software clear
  always_ff @(posedge CORE_CLK)
  begin
    if (supply_rise)
      supply_loss_flag_reg <= 1'b1;
    else if (wr_pc)
      supply_loss_flag_reg <= ACCESS.wdata[`SPPR_PC_SUPPLY_LOSS];
  end

  // Mode requests: an interrupt clears them even if written in the same cycle,
  // otherwise the core could fall asleep past the wake event
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST || INTERRUPT_TAKEN)
    begin
      powerdown_request_reg <= 1'b0;
      cpu_sleep_request_reg <= 1'b0;
    end
    else if (wr_pc)
    begin
      powerdown_request_reg <= ACCESS.wdata[`SPPR_PC_POWERDOWN];
      cpu_sleep_request_reg <= ACCESS.wdata[`SPPR_PC_SLEEP];
    end
  end

  // Exported controls, one driver for the whole struct
  assign POWER_CTRL = '{
    baud_doubler: baud_doubler_reg,
    serial_bit7_select: serial_bit7_select_reg,
    powerdown: powerdown_request_reg,
    idle: cpu_sleep_request_reg
  };

  // Powerdown takes precedence when both requests are set
  always_comb
  begin
    if (powerdown_request_reg)
      POWER_MODE = sppr_pkg::SPPR_MODE_POWERDOWN;
    else if (cpu_sleep_request_reg)
      POWER_MODE = sppr_pkg::SPPR_MODE_IDLE;
    else
      POWER_MODE = sppr_pkg::SPPR_MODE_RUN;
  end

  // Doubling applies only with timer 1 as baud source and modes 1 to 3
  assign BAUD_DOUBLE_ACTIVE = baud_doubler_reg && TIMER1_BAUD_SEL && (SERIAL_MODE != 2'b00);

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] power_read;
  assign power_read = {baud_doubler_reg, serial_bit7_select_reg, 1'b0, supply_loss_flag_reg,
                       user_flag_b_reg, user_flag_a_reg, powerdown_request_reg, cpu_sleep_request_reg};

  // Ports return latch for read-modify-write, synchronised pins otherwise
  function automatic logic [7:0] port_view(input logic rmw, input logic [7:0] latch, input logic [7:0] pins);
    port_view = rmw ? latch : pins;
  endfunction

  logic [7:0] rdata_next;
  always_comb
  begin
    unique case (ACCESS.addr)
      `SPPR_ADDR_PORT0: rdata_next = port_view(ACCESS.rmw, port0_output_latch_reg, pins_sync_reg[7:0]);
      `SPPR_ADDR_PORT1: rdata_next = port_view(ACCESS.rmw, port1_output_latch_reg, pins_sync_reg[15:8]);
      `SPPR_ADDR_PORT2: rdata_next = port_view(ACCESS.rmw, port2_output_latch_reg, pins_sync_reg[23:16]);
      `SPPR_ADDR_PORT3: rdata_next = port_view(ACCESS.rmw, port3_output_latch_reg, pins_sync_reg[31:24]);
      `SPPR_ADDR_POWER: rdata_next = power_read;
      `SPPR_ADDR_PRIO_UPPER: rdata_next = {1'b0, interrupt_priority_upper_reg};
      `SPPR_ADDR_PRIO_LOWER: rdata_next = {1'b0, interrupt_priority_lower_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data is registered, valid one cycle after the request
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      RDATA <= 8'h00;
      RVALID <= 1'b0;
    end
    else
    begin
      RDATA <= ACCESS.rd ? rdata_next : 8'h00;
      RVALID <= ACCESS.rd;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  port_reset_a: assert property (@(posedge CORE_CLK) SRST |=> PORT1_OUT == 8'hFF && PORT3_OUT == 8'hFF)
    else $error("port latch not all ones after reset");

  port_write_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_p2 |=> PORT2_OUT == $past(ACCESS.wdata))
    else $error("port 2 write not driven out");

  bus_fill_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    EXT_BUS_CYCLE |=> PORT0_OUT == 8'hFF)
    else $error("port 0 not filled on bus cycle");

  rmw_latch_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    ACCESS.rd && ACCESS.rmw && ACCESS.addr == 8'h90 && !wr_p1 |=> RDATA == $past(PORT1_OUT))
    else $error("rmw read did not return latch");

  pin_read_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    ACCESS.rd && !ACCESS.rmw && ACCESS.addr == 8'hB0 |=> RDATA == $past(PORT3_PINS, 3))
    else $error("plain read did not return pins");

  reserved_zero_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    RVALID |-> !(RDATA[7] && $past(ACCESS.addr) inside {8'hB7, 8'hB8}) && !(RDATA[5] && $past(ACCESS.addr) == 8'h87))
    else $error("reserved bit read nonzero");

  level_map_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_ipu ##1 wr_ipl |=> PRIORITY_LEVELS[13:12] == {$past(ACCESS.wdata[6], 2), $past(ACCESS.wdata[6])})
    else $error("counter array level mismatch");

  wake_clear_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    INTERRUPT_TAKEN |=> !POWER_CTRL.idle && !POWER_CTRL.powerdown)
    else $error("mode request survived interrupt");

  pd_wins_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    POWER_CTRL.powerdown |-> POWER_MODE == sppr_pkg::SPPR_MODE_POWERDOWN)
    else $error("idle taken over powerdown");

  supply_set_a: assert property (@(posedge CORE_CLK)
    supply_rise |=> supply_loss_flag_reg)
    else $error("supply-loss flag not set");

  baud_gate_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    SERIAL_MODE == 2'b00 || !TIMER1_BAUD_SEL |-> !BAUD_DOUBLE_ACTIVE)
    else $error("baud doubled outside allowed modes");

  baud_active_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    POWER_CTRL.baud_doubler && TIMER1_BAUD_SEL && SERIAL_MODE != 2'b00 |-> BAUD_DOUBLE_ACTIVE)
    else $error("baud not doubled in allowed modes");

  bit7_select_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_pc |=> POWER_CTRL.serial_bit7_select == $past(ACCESS.wdata[6]))
    else $error("serial bit 7 select not written");

  user_flags_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_pc |=> {user_flag_b_reg, user_flag_a_reg} == $past(ACCESS.wdata[3:2]))
    else $error("user flags not written");

  pd_write_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_pc && !INTERRUPT_TAKEN |=> POWER_CTRL.powerdown == $past(ACCESS.wdata[1]))
    else $error("powerdown request not written");

  idle_mode_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    POWER_CTRL.idle && !POWER_CTRL.powerdown |-> POWER_MODE == sppr_pkg::SPPR_MODE_IDLE)
    else $error("idle request not reflected in mode");

endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
`include "sppr_map.svh"
module tb_top;
  logic CORE_CLK;
  logic SRST;
  sppr_pkg::sppr_access_type acc;
  logic [7:0] RDATA;
  logic RVALID;
  logic [7:0] pins [4];
  logic [7:0] pout [4];
  logic ext_bus;
  logic supply;
  logic irq_taken;
  logic t1_sel;
  logic [1:0] smode;
  logic [13:0] levels;
  sppr_pkg::sppr_power_type pctl;
  sppr_pkg::sppr_mode_type pmode;
  logic baud_act;
  logic [13:0] lvl_exp;
  logic [7:0] paddr [4];
  int n_fail;
  int compares;
  int cycles;

  sppr_bank dut_u
  (
    .CORE_CLK(CORE_CLK),
    .SRST(SRST),
    .ACCESS(acc),
    .RDATA(RDATA),
    .RVALID(RVALID),
    .PORT0_PINS(pins[0]),
    .PORT1_PINS(pins[1]),
    .PORT2_PINS(pins[2]),
    .PORT3_PINS(pins[3]),
    .PORT0_OUT(pout[0]),
    .PORT1_OUT(pout[1]),
    .PORT2_OUT(pout[2]),
    .PORT3_OUT(pout[3]),
    .EXT_BUS_CYCLE(ext_bus),
    .SUPPLY_RESTORED(supply),
    .INTERRUPT_TAKEN(irq_taken),
    .TIMER1_BAUD_SEL(t1_sel),
    .SERIAL_MODE(smode),
    .PRIORITY_LEVELS(levels),
    .POWER_CTRL(pctl),
    .POWER_MODE(pmode),
    .BAUD_DOUBLE_ACTIVE(baud_act)
  );

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial
  begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end

  // The whole run needs under a hundred cycles, so 3000 is generous
  always @(posedge CORE_CLK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Every task starts and ends just after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask

  // An idle cycle follows each access so ACCESS never changes twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc = '{rd: 1'b0, wr: 1'b1, rmw: 1'b0, addr: a, wdata: d};
    cyc(1);
    acc = '0;
    cyc(1);
  endtask

  // Read data stands for one cycle only, so it is taken right after the edge
  task automatic rdc(input logic [7:0] a, input logic m, input logic [7:0] mask, input logic [7:0] exp);
    acc = '{rd: 1'b1, wr: 1'b0, rmw: m, addr: a, wdata: 8'h00};
    cyc(1);
    acc = '0;
    chk(16'(RVALID), 16'h0001);
    chk(16'(RDATA & mask), 16'(exp));
    cyc(1);
    chk(16'(RVALID), 16'h0000);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    paddr = '{`SPPR_ADDR_PORT0, `SPPR_ADDR_PORT1, `SPPR_ADDR_PORT2, `SPPR_ADDR_PORT3};
    acc = '0;
    pins = '{8'h00, 8'h00, 8'h00, 8'h00};
    {ext_bus, supply, irq_taken, t1_sel, smode} = 6'h00;
    SRST = 1'b1;
    cyc(2);
    SRST = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rdc(paddr[i], 1'b1, 8'hFF, 8'hFF);
      chk(16'(pout[i]), 16'h00FF);
    end
    rdc(`SPPR_ADDR_PRIO_UPPER, 1'b0, 8'hFF, 8'h00);
    rdc(`SPPR_ADDR_PRIO_LOWER, 1'b0, 8'hFF, 8'h00);
    // Supply-loss flag is not reset, so bit 4 is masked here
    rdc(`SPPR_ADDR_POWER, 1'b0, 8'hEF, 8'h00);
    // Levels 3,1,2,0 repeat across the sources, so every code is seen
    wr(`SPPR_ADDR_PRIO_UPPER, 8'h55);
    wr(`SPPR_ADDR_PRIO_LOWER, 8'h33);
    for (int n = 0; n < 7; n++)
      lvl_exp[2*n +: 2] = {n[0] ? 1'b0 : 1'b1, n[1] ? 1'b0 : 1'b1};
    chk(16'(levels), 16'(lvl_exp));
    rdc(`SPPR_ADDR_PRIO_UPPER, 1'b0, 8'hFF, 8'h55);
    rdc(`SPPR_ADDR_PRIO_LOWER, 1'b0, 8'hFF, 8'h33);
    // Back-to-back writes, upper then lower, with no idle cycle between
    acc = '{rd: 1'b0, wr: 1'b1, rmw: 1'b0, addr: `SPPR_ADDR_PRIO_UPPER, wdata: 8'h40};
    cyc(1);
    acc = '{rd: 1'b0, wr: 1'b1, rmw: 1'b0, addr: `SPPR_ADDR_PRIO_LOWER, wdata: 8'h00};
    cyc(1);
    acc = '0;
    cyc(1);
    chk(16'(levels), 16'h2000);
    // Pins differ from latches so the two read paths can be told apart
    for (int i = 0; i < 4; i++)
      pins[i] = ~8'(8'h3C + i);
    cyc(4);
    for (int i = 0; i < 4; i++)
    begin
      wr(paddr[i], 8'(8'h3C + i));
      chk(16'(pout[i]), 16'(8'(8'h3C + i)));
      rdc(paddr[i], 1'b1, 8'hFF, 8'(8'h3C + i));
      rdc(paddr[i], 1'b0, 8'hFF, pins[i]);
    end
    // External bus cycle overwrites port 0 latch
    ext_bus = 1'b1;
    cyc(1);
    ext_bus = 1'b0;
    chk(16'(pout[0]), 16'h00FF);
    rdc(`SPPR_ADDR_PORT0, 1'b1, 8'hFF, 8'hFF);
    // Power requests, precedence and hardware clear
    wr(`SPPR_ADDR_POWER, 8'h03);
    chk(16'(pmode), 16'(sppr_pkg::SPPR_MODE_POWERDOWN));
    chk(16'({pctl.powerdown, pctl.idle}), 16'h0003);
    irq_taken = 1'b1;
    cyc(1);
    irq_taken = 1'b0;
    chk(16'({pctl.powerdown, pctl.idle}), 16'h0000);
    chk(16'(pmode), 16'(sppr_pkg::SPPR_MODE_RUN));
    wr(`SPPR_ADDR_POWER, 8'h01);
    chk(16'(pmode), 16'(sppr_pkg::SPPR_MODE_IDLE));
    SRST = 1'b1;
    cyc(1);
    SRST = 1'b0;
    chk(16'(pmode), 16'(sppr_pkg::SPPR_MODE_RUN));
    chk(16'(pout[1]), 16'h00FF);
    // Doubler only acts with timer 1 and a mode other than 0
    wr(`SPPR_ADDR_POWER, 8'h80);
    for (int t = 0; t < 2; t++)
      for (int m = 0; m < 4; m++)
      begin
        t1_sel = t[0];
        smode = m[1:0];
        cyc(1);
        chk(16'(baud_act), 16'(t == 1 && m != 0));
      end
    t1_sel = 1'b0;
    wr(`SPPR_ADDR_POWER, 8'h40);
    chk(16'({pctl.baud_doubler, pctl.serial_bit7_select}), 16'h0001);
    // Supply rise needs two edges to pass the synchroniser and a third to set the flag
    supply = 1'b1;
    cyc(4);
    rdc(`SPPR_ADDR_POWER, 1'b0, 8'h10, 8'h10);
    wr(`SPPR_ADDR_POWER, 8'h0C);
    rdc(`SPPR_ADDR_POWER, 1'b0, 8'hFF, 8'h0C);
    chk(16'(pmode), 16'(sppr_pkg::SPPR_MODE_RUN));
    // Unmapped address answers with zero and does not disturb a latch
    rdc(8'h81, 1'b0, 8'hFF, 8'h00);
    wr(8'h81, 8'hAA);
    chk(16'(pout[1]), 16'h00FF);
    end_of_test();
  end
endmodule
